/* logic/lvdstx_pkg.sv */
// constants shared by the three-lane panel link serializer
package lvdstx_pkg;
	// word and lane layout
	localparam int COLOR_BITS = 18;
	localparam int SYNC_BITS = 3;
	localparam int WORD_BITS = COLOR_BITS + SYNC_BITS;
	localparam int NUM_LANES = 3;
	localparam int SLOTS = 7;
	localparam int LINE_SYNC_POS = 18;
	localparam int FRAME_SYNC_POS = 19;
	localparam int DATA_ENABLE_POS = 20;
	localparam logic [2:0] SLOT_LAST = 3'(SLOTS - 1);
	localparam logic [2:0] SLOT_FIRST = 3'h0;
	// clock lane shape per word period, slot 0 first
	localparam logic [SLOTS-1:0] CLOCK_LANE_PATTERN = 7'h63;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 21'h0;
	// timing in the 100 MHz system domain
	localparam int CLK_PERIOD_NSEC = 10;
	localparam int MISS_TIME_NSEC = 500;
	localparam int RELOCK_TIME_NSEC = 1000;
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
	// longest time rounds down
	localparam logic [CNT_W-1:0] MISS_CYCLES = CNT_W'(MISS_TIME_NSEC / CLK_PERIOD_NSEC);
	// least time rounds up
	localparam logic [CNT_W-1:0] RELOCK_CYCLES = CNT_W'((RELOCK_TIME_NSEC + CLK_PERIOD_NSEC - 1) / CLK_PERIOD_NSEC);
endpackage

/* logic/lvdstx_lane_shifter.sv */
// one serial lane: loads a slot word and shifts it out, slot 0 first
`timescale 1ns/1ps
module lvdstx_lane_shifter #(
	parameter int WIDTH = lvdstx_pkg::SLOTS
) (
	// bit clock domain
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] loadWord,
	input wire logic active,
	// serial output
	output logic serialOut
);
	typedef struct packed {
		logic [WIDTH-1:0] shift;
		logic outBit;
	} lvdstx_lane_t;

	lvdstx_lane_t st_reg;
	lvdstx_lane_t st_next;

	always_comb begin
		st_next = st_reg;
		if (load) begin
			st_next.shift = loadWord >> 1;
			st_next.outBit = loadWord[0];
		end else begin
			st_next.shift = st_reg.shift >> 1;
			st_next.outBit = st_reg.shift[0];
		end
		// idle lanes sit at logic low
		if (!active) begin
			st_next.outBit = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign serialOut = st_reg.outBit;
endmodule

/* logic/lvdstx_link_serializer.sv */
// three-lane panel link serializer with forwarded clock lane
// Summary of operation
// - twenty-one parallel input bits are spread over three serial data lanes.
// - the PLL-derived clock goes out on a fourth lane in step with data.
// - every input clock cycle captures all 21 bits and serializes them.
// - each data lane carries seven bit slots per input clock period.
// - inputs are always sampled on the falling edge of the input clock.
// - powered up but clock missing, every lane including clock drives low.
// - clock, data and power-down may arrive in any order.
// - serialization stays correct under spread-spectrum input clocking.
`timescale 1ns/1ps
module lvdstx_link_serializer (
	// system domain
	input wire logic clk,
	input wire logic sys_rst,
	// parallel link side
	input wire logic parallel_clock_in,
	input wire logic [lvdstx_pkg::COLOR_BITS-1:0] parallel_data_in,
	input wire logic line_sync_in,
	input wire logic frame_sync_in,
	input wire logic pixel_data_enable_in,
	input wire logic power_down_n,
	// pll macro, seven times the input clock
	input wire logic bitClk,
	input wire logic pllLocked,
	output logic pllEnable,
	// serial lanes
	output logic [lvdstx_pkg::NUM_LANES-1:0] laneData,
	output logic clockLane,
	output logic laneOutEnable
);
	////////////////////////////////////////////////////////////////
	// capture domain, falling edge of the input clock
	// word and toggle change together; readers wait for the toggle to settle
	// the capture reset is synchronised here, so reset must span a few input clock edges
	typedef struct packed {
		logic rstMeta;
		logic rstSync;
		logic [lvdstx_pkg::WORD_BITS-1:0] wordHold;
		logic toggle;
	} lvdstx_cap_t;

	lvdstx_cap_t cap_reg;
	lvdstx_cap_t cap_next;

	always_comb begin
		cap_next = cap_reg;
		cap_next.rstMeta = sys_rst;
		cap_next.rstSync = cap_reg.rstMeta;
		if (cap_reg.rstSync) begin
			cap_next.wordHold = lvdstx_pkg::WORD_RESET;
			cap_next.toggle = 1'b0;
		end else begin
			// whole word taken every input cycle
			cap_next.wordHold[lvdstx_pkg::COLOR_BITS-1:0] = parallel_data_in;
			cap_next.wordHold[lvdstx_pkg::LINE_SYNC_POS] = line_sync_in;
			cap_next.wordHold[lvdstx_pkg::FRAME_SYNC_POS] = frame_sync_in;
			cap_next.wordHold[lvdstx_pkg::DATA_ENABLE_POS] = pixel_data_enable_in;
			cap_next.toggle = ~cap_reg.toggle;
		end
	end

	// fixed falling-edge strobe
	always_ff @(negedge parallel_clock_in) begin
		cap_reg <= cap_next;
	end

	////////////////////////////////////////////////////////////////
	// system domain: pin sync, clock detection, power-down and relock
	// the heartbeat is the capture toggle: a stopped input clock freezes it
	// the detector needs the bit clock to keep running to pull the lanes low
	typedef struct packed {
		logic pdMeta;
		logic pdSync;
		logic lockMeta;
		logic lockSync;
		logic hbMeta;
		logic hbSync;
		logic hbLast;
		logic [lvdstx_pkg::CNT_W-1:0] missCnt;
		logic clockMissing;
		logic [lvdstx_pkg::CNT_W-1:0] relockCnt;
		logic linkActive;
		logic pllEnable;
		logic outEnable;
	} lvdstx_sys_t;

	lvdstx_sys_t sys_reg;
	lvdstx_sys_t sys_next;

	always_comb begin
		sys_next = sys_reg;
		sys_next.pdMeta = power_down_n;
		sys_next.pdSync = sys_reg.pdMeta;
		sys_next.lockMeta = pllLocked;
		sys_next.lockSync = sys_reg.lockMeta;
		sys_next.hbMeta = cap_reg.toggle;
		sys_next.hbSync = sys_reg.hbMeta;
		sys_next.hbLast = sys_reg.hbSync;
		// any capture edge restarts the watchdog
		if (sys_reg.hbSync != sys_reg.hbLast) begin
			sys_next.missCnt = lvdstx_pkg::CNT_ZERO;
		end else if (sys_reg.missCnt != lvdstx_pkg::MISS_CYCLES) begin
			sys_next.missCnt = sys_reg.missCnt + lvdstx_pkg::CNT_ONE;
		end
		sys_next.clockMissing = (sys_reg.missCnt == lvdstx_pkg::MISS_CYCLES);
		// relock wait restarts whenever power or lock drops
		if (!sys_reg.pdSync || !sys_reg.lockSync) begin
			sys_next.relockCnt = lvdstx_pkg::CNT_ZERO;
		end else if (sys_reg.relockCnt != lvdstx_pkg::RELOCK_CYCLES) begin
			sys_next.relockCnt = sys_reg.relockCnt + lvdstx_pkg::CNT_ONE;
		end
		// no start-up order is assumed: power and lock re-enter through the same wait; a returning input clock does not
		sys_next.linkActive = sys_reg.pdSync && sys_reg.lockSync && !sys_reg.clockMissing
			&& (sys_reg.relockCnt == lvdstx_pkg::RELOCK_CYCLES);
		// the pll and the drivers share one power state
		sys_next.pllEnable = sys_reg.pdSync;
		sys_next.outEnable = sys_reg.pdSync;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sys_reg <= '0;
		end else begin
			sys_reg <= sys_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// bit domain: word handover and slot sequencing
	// the slot counter free-runs; a stalled input clock leaves the held word in place,
	// so it repeats on the lanes until the detector drops the link
	// reset is synchronised here too, so the bit clock must run during reset
	typedef struct packed {
		logic rstMeta;
		logic rstSync;
		logic actMeta;
		logic actSync;
		logic tgMeta;
		logic tgSync;
		logic tgLast;
		logic [lvdstx_pkg::WORD_BITS-1:0] pending;
		logic [2:0] slot;
	} lvdstx_bit_t;

	lvdstx_bit_t bit_reg;
	lvdstx_bit_t bit_next;
	logic loadSlot;

	always_comb begin
		bit_next = bit_reg;
		bit_next.rstMeta = sys_rst;
		bit_next.rstSync = bit_reg.rstMeta;
		bit_next.actMeta = sys_reg.linkActive;
		bit_next.actSync = bit_reg.actMeta;
		bit_next.tgMeta = cap_reg.toggle;
		bit_next.tgSync = bit_reg.tgMeta;
		bit_next.tgLast = bit_reg.tgSync;
		// held word is stable for a whole input period after its toggle
		// taking it on the toggle, not on a fixed slot, follows a drifting input period
		if (bit_reg.tgSync != bit_reg.tgLast) begin
			bit_next.pending = cap_reg.wordHold;
		end
		// seven slots per word period
		if (bit_reg.slot == lvdstx_pkg::SLOT_LAST) begin
			bit_next.slot = lvdstx_pkg::SLOT_FIRST;
		end else begin
			bit_next.slot = bit_reg.slot + 3'h1;
		end
		if (bit_reg.rstSync) begin
			bit_next.tgLast = bit_reg.tgSync;
			bit_next.pending = lvdstx_pkg::WORD_RESET;
			bit_next.slot = lvdstx_pkg::SLOT_FIRST;
		end
	end

	always_ff @(posedge bitClk) begin
		bit_reg <= bit_next;
	end

	// slot 6 loads the next word so its slot 0 follows without a gap
	assign loadSlot = (bit_reg.slot == lvdstx_pkg::SLOT_LAST);

	////////////////////////////////////////////////////////////////
	// lanes
	genvar lane;
	generate
		for (lane = 0; lane < lvdstx_pkg::NUM_LANES; lane++) begin : gLane
			// seven inputs per lane
			lvdstx_lane_shifter #(
				.WIDTH(lvdstx_pkg::SLOTS)
			) uData (
				.clk(bitClk),
				.rst(bit_reg.rstSync),
				.load(loadSlot),
				.loadWord(bit_reg.pending[lane*lvdstx_pkg::SLOTS +: lvdstx_pkg::SLOTS]),
				.active(bit_reg.actSync),
				.serialOut(laneData[lane])
			);
		end
	endgenerate

	// forwarded clock shares slot timing with the data lanes
	lvdstx_lane_shifter #(
		.WIDTH(lvdstx_pkg::SLOTS)
	) uClockLane (
		.clk(bitClk),
		.rst(bit_reg.rstSync),
		.load(loadSlot),
		.loadWord(lvdstx_pkg::CLOCK_LANE_PATTERN),
		.active(bit_reg.actSync),
		.serialOut(clockLane)
	);

	// enables follow the synced pin alone, so power-down floats the lanes without a bit clock
	assign pllEnable = sys_reg.pllEnable;
	assign laneOutEnable = sys_reg.outEnable;
endmodule

/* verification/lvdstx_rx_model.sv */
// falling-edge panel receiver model: frames lanes on the clock lane shape
`timescale 1ns/1ps
module lvdstx_rx_model (
	// serial side
	input wire logic bitClk,
	input wire logic [lvdstx_pkg::NUM_LANES-1:0] laneData,
	input wire logic clockLane,
	// recovered word
	output logic [lvdstx_pkg::WORD_BITS-1:0] rxWord,
	output logic rxValid
);
	logic [6:0] ckSr = 7'h00;
	logic [6:0] s0;
	logic [6:0] s1;
	logic [6:0] s2;
	// sample mid-bit, away from the edge that launches the lanes
	always_ff @(negedge bitClk) begin
		ckSr <= {clockLane, ckSr[6:1]};
		s0 <= {laneData[0], s0[6:1]};
		s1 <= {laneData[1], s1[6:1]};
		s2 <= {laneData[2], s2[6:1]};
		// word boundary sits where the last seven clock slots match the shape
		rxValid <= ({clockLane, ckSr[6:1]} == lvdstx_pkg::CLOCK_LANE_PATTERN);
		rxWord <= {laneData[2], s2[6:1], laneData[1], s1[6:1], laneData[0], s0[6:1]};
	end
endmodule

/* verification/lvdstx_link_chk.sv */
// port assertions for the panel link serializer
`timescale 1ns/1ps
module lvdstx_link_chk (
	// clocks and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic bitClk,
	// watched pins
	input wire logic parallel_clock_in,
	input wire logic power_down_n,
	input wire logic pllEnable,
	input wire logic [lvdstx_pkg::NUM_LANES-1:0] laneData,
	input wire logic clockLane,
	input wire logic laneOutEnable
);
	logic pcSeen;
	logic [7:0] idleCnt;
	// cycles since the input clock last moved
	always_ff @(posedge clk) begin
		pcSeen <= parallel_clock_in;
		if (sys_rst || pcSeen != parallel_clock_in)
			idleCnt <= 8'h00;
		else if (idleCnt != 8'hff)
			idleCnt <= idleCnt + 8'h01;
	end
	pd_drop_a: assert property (@(posedge clk) disable iff (sys_rst) $fell(power_down_n)
		|-> ##[1:4] (!pllEnable && !laneOutEnable)) else $error("power down not obeyed");
	pd_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!power_down_n) [*4] |-> !pllEnable) else $error("pll kept running");
	pd_wake_a: assert property (@(posedge clk) disable iff (sys_rst) $rose(power_down_n)
		|-> ##[1:4] (pllEnable && laneOutEnable)) else $error("no wake up");
	en_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
		(laneOutEnable == pllEnable && pllEnable == $past(power_down_n, 3))) else $error("enables disagree with pin");
	off_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
		(!laneOutEnable) [*8] |-> (laneData == '0 && !clockLane)) else $error("lanes active while off");
	miss_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		idleCnt > 8'h50 |-> (laneData == '0 && !clockLane)) else $error("lanes not low on lost clock");
	ck_gap_a: assert property (@(posedge bitClk) disable iff (sys_rst) $fell(clockLane)
		|-> (!clockLane) [*3] ##1 (clockLane || laneData == '0)) else $error("clock lane shape wrong");
	ck_dead_a: assert property (@(posedge bitClk) disable iff (sys_rst)
		(!clockLane) [*8] |-> laneData == '0) else $error("data without clock lane");
	cover property (@(posedge clk) $fell(power_down_n));
	cover property (@(posedge clk) idleCnt == 8'h51);
	cover property (@(posedge bitClk) $rose(clockLane));
endmodule
bind lvdstx_link_serializer lvdstx_link_chk u_chk (.clk, .sys_rst, .bitClk, .parallel_clock_in, .power_down_n,
	.pllEnable, .laneData, .clockLane, .laneOutEnable);

/* verification/lvdstx_link_serializer_tb.sv */
// self-checking bench for the panel link serializer
`timescale 1ns/1ps
module lvdstx_link_serializer_tb;
	logic clk = 1'b0;
	logic bitClk = 1'b0;
	logic sys_rst = 1'b1;
	logic parallel_clock_in = 1'b0;
	logic [17:0] parallel_data_in = 18'h0;
	logic line_sync_in = 1'b0, frame_sync_in = 1'b0, pixel_data_enable_in = 1'b0;
	logic power_down_n = 1'b0, pllLocked = 1'b0, run = 1'b1, hunt = 1'b1, hold = 1'b0, lockOk = 1'b1;
	logic pllEnable, clockLane, laneOutEnable, rxValid;
	logic [2:0] laneData;
	logic [2:0] ph = 3'h0;
	logic [20:0] rxWord, expW;
	logic [20:0] lastW = 21'h0;
	logic [20:0] q[$];
	int seed = 83211, checked = 0, errTotal = 0, rcv = 0;
	lvdstx_link_serializer u_dut (.clk, .sys_rst, .parallel_clock_in, .parallel_data_in, .line_sync_in,
		.frame_sync_in, .pixel_data_enable_in, .power_down_n, .bitClk, .pllLocked, .pllEnable, .laneData,
		.clockLane, .laneOutEnable);
	lvdstx_rx_model u_rx (.bitClk, .laneData, .clockLane, .rxWord, .rxValid);
	always #5 clk = ~clk;
	always #(16.0 / 7) bitClk = ~bitClk;
	// pixel clock is one seventh of the bit clock, held still when run is low
	always @(posedge bitClk) begin
		ph <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
		if (run)
			parallel_clock_in <= (ph < 3'h4);
	end
	// the pll holds lock while the input clock is missing, so only the detector drops the link
	always @(negedge clk) pllLocked <= pllEnable & lockOk;
	always @(posedge parallel_clock_in) begin
		{pixel_data_enable_in, frame_sync_in, line_sync_in, parallel_data_in} = 21'($random(seed));
		q.push_back({pixel_data_enable_in, frame_sync_in, line_sync_in, parallel_data_in});
	end
	task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
		checked++;
		if (g !== e) begin
			errTotal++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", checked, errTotal);
		if (errTotal == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic waitRx(input int n);
		int t;
		t = rcv + n;
		for (int i = 0; i < 4000 && rcv < t; i++)
			@(negedge clk);
		if (rcv < t) begin
			errTotal++;
			$display("unexpected rx count expected %0d seen %0d", t, rcv);
			wrapUp();
		end
	endtask
	// after a restart, skip words dropped while the link was down
	// while the input clock is stopped, repeats of the held word are not new words
	always @(posedge bitClk) begin
		if (rxValid === 1'b1) begin
			if (!(hold && rxWord === lastW)) begin
				while (hunt && q.size() > 0 && q[0] !== rxWord)
					void'(q.pop_front());
				hunt = 1'b0;
				expW = (q.size() > 0) ? q.pop_front() : ~rxWord;
				chk("word", expW, rxWord);
				lastW = rxWord;
			end
			rcv++;
		end
	end
	initial begin
		int r0;
		repeat (6) @(negedge parallel_clock_in);
		@(negedge clk);
		sys_rst = 1'b0;
		run = 1'b0;
		power_down_n = 1'b1;
		repeat (20) @(negedge clk);
		q.delete();
		run = 1'b1;
		waitRx(30);
		chk("enables", 21'h3, {pllEnable, laneOutEnable});
		$display("test start order done");
		run = 1'b0;
		hold = 1'b1;
		repeat (100) @(negedge clk);
		chk("lanes idle", 21'h1, {clockLane, laneData, laneOutEnable});
		hunt = 1'b1;
		run = 1'b1;
		waitRx(20);
		hold = 1'b0;
		$display("test clock loss done");
		lockOk = 1'b0;
		repeat (20) @(negedge clk);
		chk("lock lost", 21'h1, {clockLane, laneData, laneOutEnable});
		hunt = 1'b1;
		lockOk = 1'b1;
		waitRx(20);
		$display("test relock done");
		power_down_n = 1'b0;
		repeat (10) @(negedge clk);
		chk("power down", 21'h0, {pllEnable, laneOutEnable, clockLane, laneData});
		r0 = rcv;
		repeat (100) @(negedge clk);
		chk("dropped", 21'(r0), 21'(rcv));
		hunt = 1'b1;
		q.delete();
		power_down_n = 1'b1;
		waitRx(20);
		$display("test power down done");
		wrapUp();
	end
endmodule
